// File: verilog/dbg_access_pkg.sv
// Constants of the debug-port access-layer registers.
// Shared by the register block and its status sampler.
package dbg_access_pkg;
  localparam logic [3:0] system_reset_request_offset = 4'h8;
  localparam logic [3:0] debug_clock_control_offset = 4'h9;
  localparam logic [3:0] system_control_offset = 4'hA;
  localparam logic [3:0] system_status_offset = 4'hB;
  localparam logic [3:0] memory_scan_crc_status_offset = 4'hC;
  localparam logic [7:0] reset_signature = 8'h59;
  localparam logic [1:0] clock_select_16mhz = 2'h1;
  localparam logic [1:0] clock_select_8mhz = 2'h2;
  localparam logic [1:0] clock_select_4mhz = 2'h3;
  localparam logic [1:0] clock_select_reset = 2'h3;
  localparam int user_row_done_bit = 1;
  localparam int system_clock_request_bit = 0;
  localparam int system_reset_active_bit = 5;
  localparam int system_sleeping_bit = 4;
  localparam int nvm_programming_permitted_bit = 3;
  localparam int user_row_programming_permitted_bit = 2;
  localparam int device_locked_bit = 0;
  localparam logic [2:0] crc_not_enabled = 3'h0;
  localparam logic [2:0] crc_busy = 3'h1;
  localparam logic [2:0] crc_done_ok = 3'h2;
  localparam logic [2:0] crc_done_failed = 3'h4;
  localparam logic [7:0] system_status_reset = 8'h01;
  typedef enum logic [1:0] {
    crc_idle = 2'b00,
    crc_running = 2'b01,
    crc_passed = 2'b11,
    crc_failed = 2'b10
  } crc_state_type;
endpackage

// File: verilog/status_sampler.sv
// Registered sampler for the status levels the system domain presents.
// Assumes its inputs are synchronous to clk.
`timescale 1ns/1ps
module status_sampler (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] raw,
  output logic [7:0] held
);
  import dbg_access_pkg::*;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      held <= system_status_reset;
    end else begin
      held <= raw;
    end
  end
endmodule

// File: verilog/dbg_access_regs.sv
// Access-layer control and status registers of the single-wire debug port.
// Assumes a port-internal register strobe interface on the debug-port clock;
// rstn is the port-disable reset and is never driven by the system reset.
// Summary of operation
// - Writing 0x59 holds system reset.
// - Any other value written to offset 0x8 releases held reset.
// - Bit 0 shows held reset; others zero.
// - System reset never resets this block.
// - Clock select 1/2/3 = 16/8/4 MHz.
// - User-row-done write starts flash programming.
// - Early done write: processor continues anyway.
// - User-row-done writable only with key.
// - Clock request bit written one/zero.
// - Clock request set on enable.
// - Reset-active bit set, cleared on read.
// - Sleeping bit follows system sleep.
// - NVM programming permitted status shown.
// - User-row programming permitted status shown.
// - Lock bit reads one until erased.
// - CRC field is one-hot scan status.
// - Only the debug port reads these.
// - User-row key status bit shown.
`timescale 1ns/1ps
module dbg_access_regs (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [3:0] reg_address,
  input wire logic [7:0] reg_write_data,
  output logic [7:0] reg_read_data,
  output logic [7:0] key_status,
  output logic system_reset_hold,
  output logic [1:0] debug_clock_select,
  output logic system_clock_request,
  output logic user_row_done,
  input wire logic user_row_write_key_active,
  input wire logic system_in_reset,
  input wire logic system_sleeping,
  input wire logic nvm_programming_permitted,
  input wire logic user_row_programming_permitted,
  input wire logic device_locked,
  input wire logic crc_enabled,
  input wire logic crc_finished,
  input wire logic crc_signature_good
);
  import dbg_access_pkg::*;

  logic [7:0] raw_status;
  logic [7:0] sampled;
  logic reset_active_sticky;
  logic status_read;
  logic [2:0] crc_code;
  crc_state_type crc_state;
  crc_state_type next_crc_state;

  assign status_read = reg_read && reg_address == system_status_offset;
  assign key_status = {2'h0, user_row_write_key_active, 5'h00};

  always_comb begin
    raw_status = 8'h00;
    raw_status[system_sleeping_bit] = system_sleeping;
    raw_status[nvm_programming_permitted_bit] = nvm_programming_permitted;
    raw_status[user_row_programming_permitted_bit] = user_row_programming_permitted;
    raw_status[device_locked_bit] = device_locked;
  end

  status_sampler u_sampler (
    .clk(clk),
    .rstn(rstn),
    .raw(raw_status),
    .held(sampled)
  );

  // The block sees only rstn, so a held system reset keeps the session alive.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      system_reset_hold <= 1'b0;
    end else if (reg_write && reg_address == system_reset_request_offset) begin
      system_reset_hold <= (reg_write_data == reset_signature);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      debug_clock_select <= clock_select_reset;
    end else if (reg_write && reg_address == debug_clock_control_offset) begin
      if (reg_write_data[1:0] != 2'h0) begin
        debug_clock_select <= reg_write_data[1:0];
      end
    end
  end

  // Port enable is rstn release, so the request comes up set.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      system_clock_request <= 1'b1;
    end else if (reg_write && reg_address == system_control_offset) begin
      system_clock_request <= reg_write_data[system_clock_request_bit];
    end
  end

  // One-cycle start pulse; the flash side runs whatever RAM holds then.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      user_row_done <= 1'b0;
    end else begin
      user_row_done <= reg_write && reg_address == system_control_offset
        && reg_write_data[user_row_done_bit] && user_row_write_key_active;
    end
  end

  // A new reset event wins over the clearing read.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reset_active_sticky <= 1'b0;
    end else if (system_in_reset || system_reset_hold) begin
      reset_active_sticky <= 1'b1;
    end else if (status_read) begin
      reset_active_sticky <= 1'b0;
    end
  end

  always_comb begin
    next_crc_state = crc_state;
    case (crc_state)
      crc_idle: if (crc_enabled) next_crc_state = crc_running;
      crc_running: begin
        if (!crc_enabled) next_crc_state = crc_idle;
        else if (crc_finished) next_crc_state = crc_signature_good ? crc_passed : crc_failed;
      end
      crc_passed: if (!crc_enabled) next_crc_state = crc_idle;
      crc_failed: if (!crc_enabled) next_crc_state = crc_idle;
      default: next_crc_state = crc_idle;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crc_state <= crc_idle;
    end else begin
      crc_state <= next_crc_state;
    end
  end

  always_comb begin
    case (crc_state)
      crc_running: crc_code = crc_busy;
      crc_passed: crc_code = crc_done_ok;
      crc_failed: crc_code = crc_done_failed;
      default: crc_code = crc_not_enabled;
    endcase
  end

  // Read data only leave through this port; no processor path exists.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_read_data <= 8'h00;
    end else if (reg_read) begin
      case (reg_address)
        system_reset_request_offset: reg_read_data <= {7'h00, system_reset_hold};
        debug_clock_control_offset: reg_read_data <= {6'h00, debug_clock_select};
        system_control_offset: reg_read_data <= {7'h00, system_clock_request};
        system_status_offset: begin
          reg_read_data <= sampled | {2'h0, reset_active_sticky || system_reset_hold, 5'h00};
        end
        memory_scan_crc_status_offset: reg_read_data <= {5'h00, crc_code};
        default: reg_read_data <= 8'h00;
      endcase
    end
  end

  property p_reset_hold;
    @(posedge clk) disable iff (!rstn)
    reg_write && reg_address == system_reset_request_offset
      |=> system_reset_hold == $past(reg_write_data == reset_signature);
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset hold wrong");

  property p_reset_read;
    @(posedge clk) disable iff (!rstn)
    reg_read && reg_address == system_reset_request_offset
      |=> reg_read_data == {7'h00, $past(system_reset_hold)};
  endproperty
  a_reset_read: assert property (p_reset_read) else $error("reset readback wrong");

  property p_clock_sel;
    @(posedge clk) disable iff (!rstn)
    debug_clock_select != 2'h0;
  endproperty
  a_clock_sel: assert property (p_clock_sel) else $error("reserved clock code");

  property p_done_key;
    @(posedge clk) disable iff (!rstn)
    user_row_done |-> $past(user_row_write_key_active);
  endproperty
  a_done_key: assert property (p_done_key) else $error("done without key");

  property p_system_clock_request;
    @(posedge clk) disable iff (!rstn)
    reg_write && reg_address == system_control_offset
      |=> system_clock_request == $past(reg_write_data[0]);
  endproperty
  a_system_clock_request: assert property (p_system_clock_request) else $error("clock request wrong");

  property p_sticky;
    @(posedge clk) disable iff (!rstn)
    system_in_reset |=> reset_active_sticky;
  endproperty
  a_sticky: assert property (p_sticky) else $error("reset flag lost");

  sequence s_crc_start;
    crc_enabled && crc_state == crc_idle;
  endsequence
  property p_crc;
    @(posedge clk) disable iff (!rstn)
    s_crc_start ##1 (crc_enabled && !crc_finished) |=> crc_code == crc_busy;
  endproperty
  a_crc: assert property (p_crc) else $error("crc busy missing");

  property p_lock;
    @(posedge clk) disable iff (!rstn)
    reg_read && reg_address == system_status_offset && $past(rstn)
      |=> reg_read_data[device_locked_bit] == $past(device_locked, 2);
  endproperty
  a_lock: assert property (p_lock) else $error("lock bit wrong");

  property p_reset_release;
    @(posedge clk) disable iff (!rstn)
    reg_write && reg_address == system_reset_request_offset
      && reg_write_data != reset_signature |=> !system_reset_hold;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("reset stuck");

  property p_port_survives;
    @(posedge clk) disable iff (!rstn)
    system_reset_hold && !(reg_write && reg_address == debug_clock_control_offset)
      |=> $stable(debug_clock_select);
  endproperty
  a_port_survives: assert property (p_port_survives) else $error("port state lost");

  property p_clock_keep;
    @(posedge clk) disable iff (!rstn)
    reg_write && reg_address == debug_clock_control_offset && reg_write_data[1:0] == 2'h0
      |=> $stable(debug_clock_select);
  endproperty
  a_clock_keep: assert property (p_clock_keep) else $error("reserved code taken");

  property p_clock_write;
    @(posedge clk) disable iff (!rstn)
    reg_write && reg_address == debug_clock_control_offset && reg_write_data[1:0] != 2'h0
      |=> debug_clock_select == $past(reg_write_data[1:0]);
  endproperty
  a_clock_write: assert property (p_clock_write) else $error("select not taken");

  sequence s_done_write;
    reg_write && reg_address == system_control_offset
      && reg_write_data[user_row_done_bit] && user_row_write_key_active;
  endsequence
  property p_done_start;
    @(posedge clk) disable iff (!rstn)
    s_done_write |=> user_row_done;
  endproperty
  a_done_start: assert property (p_done_start) else $error("done write lost");

  property p_done_pulse;
    @(posedge clk) disable iff (!rstn)
    !(reg_write && reg_address == system_control_offset) |=> !user_row_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done pulse too long");

  property p_hold_flag;
    @(posedge clk) disable iff (!rstn)
    system_reset_hold |=> reset_active_sticky;
  endproperty
  a_hold_flag: assert property (p_hold_flag) else $error("held reset not flagged");

  property p_flag_clear;
    @(posedge clk) disable iff (!rstn)
    status_read && !system_in_reset && !system_reset_hold |=> !reset_active_sticky;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_flag_read;
    @(posedge clk) disable iff (!rstn)
    status_read && (reset_active_sticky || system_reset_hold)
      |=> reg_read_data[system_reset_active_bit];
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("reset flag not read");

  property p_sleep_read;
    @(posedge clk) disable iff (!rstn)
    status_read && $past(rstn)
      |=> reg_read_data[system_sleeping_bit] == $past(system_sleeping, 2);
  endproperty
  a_sleep_read: assert property (p_sleep_read) else $error("sleep bit wrong");

  sequence s_crc_finish;
    crc_state == crc_running && crc_enabled && crc_finished;
  endsequence
  property p_crc_done;
    @(posedge clk) disable iff (!rstn)
    s_crc_finish
      |=> crc_code == ($past(crc_signature_good) ? crc_done_ok : crc_done_failed);
  endproperty
  a_crc_done: assert property (p_crc_done) else $error("crc result wrong");

  property p_crc_off;
    @(posedge clk) disable iff (!rstn)
    !crc_enabled |=> crc_code == crc_not_enabled;
  endproperty
  a_crc_off: assert property (p_crc_off) else $error("crc not idle");
endmodule

// File: tb/system_model.sv
// Stand-in for the system domain behind the access-layer registers.
// Assumes the bench drives sleep_request just after a rising clk edge.
`timescale 1ns/1ps
module system_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic system_reset_hold,
  input wire logic sleep_request,
  output logic system_in_reset,
  output logic system_sleeping
);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      system_in_reset <= 1'b0;
    end else begin
      system_in_reset <= system_reset_hold;
    end
  end
  // A system held in reset cannot be asleep.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      system_sleeping <= 1'b0;
    end else begin
      system_sleeping <= sleep_request && !system_reset_hold;
    end
  end
endmodule

// File: tb/debug_port_system_access_regs_bench.sv
// Self-checking bench for the access-layer register block.
// Assumes strobes are taken on rising clk and read data lands one cycle later.
`timescale 1ns/1ps
`define check(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module debug_port_system_access_regs_bench;
  import dbg_access_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, sleep_request = 1'b0;
  logic [3:0] reg_address = 4'h0;
  logic [7:0] reg_write_data = 8'h00, reg_read_data, key_status;
  logic user_row_write_key_active = 1'b0, nvm_programming_permitted = 1'b0;
  logic user_row_programming_permitted = 1'b0, device_locked = 1'b1;
  logic crc_enabled = 1'b0, crc_finished = 1'b0, crc_signature_good = 1'b0;
  logic system_reset_hold, system_clock_request, user_row_done, system_in_reset;
  logic system_sleeping;
  logic [1:0] debug_clock_select;
  logic [1:0] sel [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
  logic [1:0] sel_exp [4] = '{2'h1, 2'h2, 2'h2, 2'h3};
  logic [2:0] crc_exp [2] = '{crc_done_ok, crc_done_failed};
  int errors = 0;
  int check_count = 0;
  dbg_access_regs dut (.clk, .rstn, .reg_write, .reg_read, .reg_address, .reg_write_data,
    .reg_read_data, .key_status, .system_reset_hold, .debug_clock_select,
    .system_clock_request, .user_row_done, .user_row_write_key_active, .system_in_reset,
    .system_sleeping, .nvm_programming_permitted, .user_row_programming_permitted,
    .device_locked, .crc_enabled, .crc_finished, .crc_signature_good);
  system_model partner (.clk, .rstn, .system_reset_hold, .sleep_request, .system_in_reset,
    .system_sleeping);
  always #25 clk = ~clk;
  task automatic step;
    @(posedge clk) #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    step();
    reg_address = a;
    reg_write_data = d;
    reg_write = 1'b1;
    step();
    reg_write = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    step();
    reg_address = a;
    reg_read = 1'b1;
    step();
    reg_read = 1'b0;
    `check(reg_read_data, exp)
  endtask
  task automatic report_and_stop;
    $display("errors=%0d check_count=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    rd(4'h8, 8'h00);
    rd(4'h9, 8'h03);
    rd(4'hA, 8'h01);
    rd(4'hB, system_status_reset);
    rd(4'hC, 8'h00);
    rd(4'h3, 8'h00);
    foreach (sel[i]) begin
      wr(4'h9, {6'h00, sel[i]});
      `check(debug_clock_select, sel_exp[i])
    end
    wr(4'h9, {6'h00, clock_select_8mhz});
    wr(4'h8, reset_signature);
    `check(system_reset_hold, 1'b1)
    rd(4'h8, 8'h01);
    rd(4'h9, 8'h02);
    rd(4'hB, 8'h21);
    wr(4'h8, 8'h58);
    `check(system_reset_hold, 1'b0)
    rd(4'h8, 8'h00);
    rd(4'hB, 8'h21);
    rd(4'hB, 8'h01);
    wr(4'h9, {6'h00, clock_select_4mhz});
    wr(4'hA, 8'h00);
    `check(system_clock_request, 1'b0)
    rd(4'hA, 8'h00);
    wr(4'hA, 8'h03);
    `check(user_row_done, 1'b0)
    `check(system_clock_request, 1'b1)
    user_row_write_key_active = 1'b1;
    user_row_programming_permitted = 1'b1;
    step();
    `check(key_status, 8'h20)
    rd(4'hB, 8'h05);
    wr(4'hA, 8'h03);
    `check(user_row_done, 1'b1)
    step();
    `check(user_row_done, 1'b0)
    user_row_write_key_active = 1'b0;
    user_row_programming_permitted = 1'b0;
    nvm_programming_permitted = 1'b1;
    device_locked = 1'b0;
    sleep_request = 1'b1;
    step();
    step();
    rd(4'hB, 8'h18);
    sleep_request = 1'b0;
    wr(4'h8, reset_signature);
    wr(4'h8, 8'h00);
    foreach (crc_exp[i]) begin
      crc_enabled = 1'b1;
      step();
      step();
      rd(4'hC, {5'h00, crc_busy});
      crc_signature_good = (i == 0);
      crc_finished = 1'b1;
      step();
      crc_finished = 1'b0;
      step();
      rd(4'hC, {5'h00, crc_exp[i]});
      crc_enabled = 1'b0;
      step();
      step();
      rd(4'hC, 8'h00);
    end
    wr(4'h9, {6'h00, clock_select_16mhz});
    wr(4'h8, reset_signature);
    rstn = 1'b0;
    step();
    `check(system_reset_hold, 1'b0)
    `check(debug_clock_select, clock_select_reset)
    `check(system_clock_request, 1'b1)
    rstn = 1'b1;
    rd(4'h8, 8'h00);
    report_and_stop();
  end
endmodule
